//--- common/processor_jtag_debug_port_regs.svh
// offsets, field positions, reset values and codes of the jtag debug port
`ifndef PROCESSOR_JTAG_DEBUG_PORT_REGS_SVH
`define PROCESSOR_JTAG_DEBUG_PORT_REGS_SVH

// apb register map
`define ADDR_W          12
`define OFS_CTRL        12'h000
`define OFS_STATUS      12'h004
`define OFS_EVCNT       12'h008

// control fields
`define CTRL_WSE_BIT    0
`define CTRL_EVCLR_BIT  1

// status fields
`define STAT_HALT_BIT   0
`define STAT_EVENT_BIT  1
`define STAT_BHOLD_BIT  2
`define STAT_PGM_BIT    3
`define STAT_EXTEST_BIT 4

// widths
`define IR_W            4
`define DR_W            32
`define DBG_W           8
`define EVCNT_W         8
`define WB_ADDR_W       30

// instruction codes
`define IR_EXTEST       4'h0
`define IR_SAMPLE       4'h1
`define IR_IDCODE       4'h2
`define IR_DBGCTRL      4'h5
`define IR_BYPASS       4'hF
`define IR_CAPTURE      4'h1

// debug control register fields
`define DBG_PGM_BIT     0
`define DBG_STOP_BIT    1
`define DBG_RESET       8'h00

// data register lengths
`define LEN_IDCODE      6'd32
`define LEN_DBGCTRL     6'd8
`define LEN_BYPASS      6'd1

// synchroniser lanes
`define SY_W            8
`define SY_TCK          0
`define SY_TMS          1
`define SY_TDI          2
`define SY_TRST         3
`define SY_SCAN         4
`define SY_HALT         5
`define SY_EVT          6
`define SY_BHA          7

`endif

//--- common/processor_jtag_debug_port_pkg.sv
// types of the jtag debug port
`include "processor_jtag_debug_port_regs.svh"
package processor_jtag_debug_port_pkg;

  typedef enum logic [3:0] {
    TAP_RESET   = 4'h0,
    TAP_IDLE    = 4'h1,
    TAP_SEL_DR  = 4'h3,
    TAP_CAP_DR  = 4'h2,
    TAP_SH_DR   = 4'h6,
    TAP_EX1_DR  = 4'h7,
    TAP_PAU_DR  = 4'h5,
    TAP_EX2_DR  = 4'h4,
    TAP_UPD_DR  = 4'hC,
    TAP_SEL_IR  = 4'hD,
    TAP_CAP_IR  = 4'hF,
    TAP_SH_IR   = 4'hE,
    TAP_EX1_IR  = 4'hA,
    TAP_PAU_IR  = 4'hB,
    TAP_EX2_IR  = 4'h9,
    TAP_UPD_IR  = 4'h8
  } tap_state_t;

  typedef struct packed {
    logic [`SY_W-1:0]      sy1;
    logic [`SY_W-1:0]      sy2;
    logic                  tck_prev;
    logic                  evt_prev;
    tap_state_t            tap;
    logic [`IR_W-1:0]      ir_sh;
    logic [`IR_W-1:0]      ir_act;
    logic [`DR_W-1:0]      dr_sh;
    logic [`DBG_W-1:0]     dbg;
    logic                  tdo;
    logic                  tdo_en;
    logic                  wse;
    logic                  evt_sticky;
    logic [`EVCNT_W-1:0]   evcnt;
    logic                  halted;
    logic                  wb_full;
    logic [`WB_ADDR_W-1:0] wb_addr;
    logic                  wb_done;
    logic [31:0]           rdata;
    logic                  slverr;
  } st_t;

endpackage

//--- src/processor_jtag_debug_port.sv
// test access port, debug sideband and apb status of the processor block
`include "processor_jtag_debug_port_regs.svh"

//
// Overview of operation
// R01: mode select and data in are taken at test clock rising edges
// R02: surrounding system pulls undriven mode select high
// R03: surrounding system pulls undriven serial data in high
// R04: tap state machine follows mode select and steers serial data
// R05: serial data enters instruction register or selected data register
// R06: active low test reset clears all port and debug logic
// R07: chain input passes to serial output when chaining selected
// R08: serial output changes only at test clock falling edges
// R09: serial output comes from instruction, data register or chain input
// R10: output enable is high while shifting out serial data
// R11: external test flag high exactly while extest instruction active
// R12: capture state raises flag and loads selected register in parallel
// R13: shift state raises flag and shifts selected register one bit
// R14: update state raises flag and updates outputs at falling edge
// R15: program bit of debug control register is driven out
// R16: debug halt input stops instruction fetch and execution
// R17: halt acknowledge is high while in debug halt mode
// R18: each forced event input assertion counts as one debug event
// R19: outside logic reports bus hold acknowledge when bus is granted away
// R20: writeback full flag and 30 bit instruction address are reported
// R21: writeback complete flag is meaningful only with writeback full
// R22: wait enable output follows the wait state enable bit
// R23: test clock runs at most half the processor clock rate
// R24: tap behaves as the standard boundary scan state machine
// R25: output enable only in shift ir and shift dr states
module processor_jtag_debug_port #(
  parameter logic [31:0] ID_CODE = 32'h0000_0001  // arbitrary value
) (
  // clock, reset, enable
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  clk_en,
  // apb slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [`ADDR_W-1:0]    paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // test access pins
  input  wire logic                  test_clock_in,
  input  wire logic                  test_mode_select_in,
  input  wire logic                  test_data_in,
  input  wire logic                  test_reset_n,
  input  wire logic                  scan_chain_in,
  output logic                       test_data_out,
  output logic                       test_data_out_enable,
  output logic                       external_test_selected,
  output logic                       capture_dr_flag,
  output logic                       shift_dr_flag,
  output logic                       update_dr_flag,
  output logic                       debug_program_bit_out,
  // debug sideband
  input  wire logic                  bus_hold_ack_in,
  input  wire logic                  debug_halt_in,
  input  wire logic                  forced_debug_event_in,
  output logic                       writeback_full,
  output logic      [`WB_ADDR_W-1:0] writeback_instr_addr,
  output logic                       writeback_complete,
  output logic                       wait_enable_out,
  output logic                       halt_acknowledge,
  // core side
  input  wire logic                  core_wb_valid,
  input  wire logic [`WB_ADDR_W-1:0] core_wb_addr,
  input  wire logic                  core_wb_done,
  output logic                       core_fetch_enable
);

  processor_jtag_debug_port_pkg::st_t q;
  processor_jtag_debug_port_pkg::st_t d;
  logic                               jtag_rst;
  logic                               tck_rise;
  logic                               tck_fall;
  logic                               tms;
  logic                               tdi;
  logic                               evt_rise;
  logic                               chain_sel;
  logic                               in_shift;
  logic                               apb_wr;

  function automatic processor_jtag_debug_port_pkg::st_t st_reset();
    processor_jtag_debug_port_pkg::st_t s;
    s        = '0;
    s.tap    = processor_jtag_debug_port_pkg::TAP_RESET;
    s.ir_act = `IR_IDCODE;
    s.ir_sh  = `IR_IDCODE;
    s.dbg    = `DBG_RESET;
    return s;
  endfunction

  localparam processor_jtag_debug_port_pkg::st_t ST_RST = st_reset();

  function automatic processor_jtag_debug_port_pkg::tap_state_t tap_next(
    input processor_jtag_debug_port_pkg::tap_state_t s,
    input logic                                      m
  );
    tap_next = s;
    unique case (s)
      processor_jtag_debug_port_pkg::TAP_RESET:  tap_next = m ?
        processor_jtag_debug_port_pkg::TAP_RESET : processor_jtag_debug_port_pkg::TAP_IDLE;
      processor_jtag_debug_port_pkg::TAP_IDLE:   tap_next = m ?
        processor_jtag_debug_port_pkg::TAP_SEL_DR : processor_jtag_debug_port_pkg::TAP_IDLE;
      processor_jtag_debug_port_pkg::TAP_SEL_DR: tap_next = m ?
        processor_jtag_debug_port_pkg::TAP_SEL_IR : processor_jtag_debug_port_pkg::TAP_CAP_DR;
      processor_jtag_debug_port_pkg::TAP_CAP_DR: tap_next = m ?
        processor_jtag_debug_port_pkg::TAP_EX1_DR : processor_jtag_debug_port_pkg::TAP_SH_DR;
      processor_jtag_debug_port_pkg::TAP_SH_DR:  tap_next = m ?
        processor_jtag_debug_port_pkg::TAP_EX1_DR : processor_jtag_debug_port_pkg::TAP_SH_DR;
      processor_jtag_debug_port_pkg::TAP_EX1_DR: tap_next = m ?
        processor_jtag_debug_port_pkg::TAP_UPD_DR : processor_jtag_debug_port_pkg::TAP_PAU_DR;
      processor_jtag_debug_port_pkg::TAP_PAU_DR: tap_next = m ?
        processor_jtag_debug_port_pkg::TAP_EX2_DR : processor_jtag_debug_port_pkg::TAP_PAU_DR;
      processor_jtag_debug_port_pkg::TAP_EX2_DR: tap_next = m ?
        processor_jtag_debug_port_pkg::TAP_UPD_DR : processor_jtag_debug_port_pkg::TAP_SH_DR;
      processor_jtag_debug_port_pkg::TAP_UPD_DR: tap_next = m ?
        processor_jtag_debug_port_pkg::TAP_SEL_DR : processor_jtag_debug_port_pkg::TAP_IDLE;
      processor_jtag_debug_port_pkg::TAP_SEL_IR: tap_next = m ?
        processor_jtag_debug_port_pkg::TAP_RESET : processor_jtag_debug_port_pkg::TAP_CAP_IR;
      processor_jtag_debug_port_pkg::TAP_CAP_IR: tap_next = m ?
        processor_jtag_debug_port_pkg::TAP_EX1_IR : processor_jtag_debug_port_pkg::TAP_SH_IR;
      processor_jtag_debug_port_pkg::TAP_SH_IR:  tap_next = m ?
        processor_jtag_debug_port_pkg::TAP_EX1_IR : processor_jtag_debug_port_pkg::TAP_SH_IR;
      processor_jtag_debug_port_pkg::TAP_EX1_IR: tap_next = m ?
        processor_jtag_debug_port_pkg::TAP_UPD_IR : processor_jtag_debug_port_pkg::TAP_PAU_IR;
      processor_jtag_debug_port_pkg::TAP_PAU_IR: tap_next = m ?
        processor_jtag_debug_port_pkg::TAP_EX2_IR : processor_jtag_debug_port_pkg::TAP_PAU_IR;
      processor_jtag_debug_port_pkg::TAP_EX2_IR: tap_next = m ?
        processor_jtag_debug_port_pkg::TAP_UPD_IR : processor_jtag_debug_port_pkg::TAP_SH_IR;
      processor_jtag_debug_port_pkg::TAP_UPD_IR: tap_next = m ?
        processor_jtag_debug_port_pkg::TAP_SEL_DR : processor_jtag_debug_port_pkg::TAP_IDLE;
    endcase
  endfunction

  // length of data register chosen by instruction
  function automatic logic [5:0] dr_len(input logic [`IR_W-1:0] ir);
    if (ir == `IR_IDCODE) begin
      dr_len = `LEN_IDCODE;
    end else if (ir == `IR_DBGCTRL) begin
      dr_len = `LEN_DBGCTRL;
    end else begin
      dr_len = `LEN_BYPASS;
    end
  endfunction

  // shift one bit toward bit 0, new bit enters at len-1
  function automatic logic [`DR_W-1:0] dr_shift(
    input logic [`DR_W-1:0] sh,
    input logic             b,
    input logic [5:0]       len
  );
    dr_shift = sh >> 1;
    for (int i = 0; i < `DR_W; i++) begin
      if (i == int'(len) - 1) begin
        dr_shift[i] = b;
      end
    end
  endfunction

  // edge and level decode of synchronised pins
  assign jtag_rst  = !q.sy2[`SY_TRST];                            // [R06]
  assign tck_rise  = q.sy2[`SY_TCK] & !q.tck_prev;                // [R01] [R23]
  assign tck_fall  = !q.sy2[`SY_TCK] & q.tck_prev;
  assign tms       = q.sy2[`SY_TMS];
  assign tdi       = q.sy2[`SY_TDI];
  assign evt_rise  = q.sy2[`SY_EVT] & !q.evt_prev;
  assign chain_sel = (q.ir_act == `IR_EXTEST) || (q.ir_act == `IR_SAMPLE);
  assign in_shift  = (q.tap == processor_jtag_debug_port_pkg::TAP_SH_IR) ||
                     (q.tap == processor_jtag_debug_port_pkg::TAP_SH_DR);
  assign apb_wr    = psel && penable && pwrite;

  always_comb begin
    d     = q;
    d.sy1 = {bus_hold_ack_in, forced_debug_event_in, debug_halt_in, scan_chain_in,
             test_reset_n, test_data_in, test_mode_select_in, test_clock_in};
    d.sy2      = q.sy1;
    d.tck_prev = q.sy2[`SY_TCK];
    d.evt_prev = q.sy2[`SY_EVT];
    // tap advance and shifting at test clock rise
    if (tck_rise) begin
      d.tap = tap_next(q.tap, tms);                               // [R04] [R24]
      if (q.tap == processor_jtag_debug_port_pkg::TAP_CAP_IR) begin
        d.ir_sh = `IR_CAPTURE;
      end
      if (q.tap == processor_jtag_debug_port_pkg::TAP_SH_IR) begin
        d.ir_sh = {tdi, q.ir_sh[`IR_W-1:1]};                      // [R05]
      end
      if (q.tap == processor_jtag_debug_port_pkg::TAP_CAP_DR) begin
        if (q.ir_act == `IR_IDCODE) begin
          d.dr_sh = ID_CODE;                                      // [R12]
        end else if (q.ir_act == `IR_DBGCTRL) begin
          d.dr_sh = {{(`DR_W-`DBG_W){1'b0}}, q.dbg};              // [R12]
        end else if (!chain_sel) begin
          d.dr_sh = '0;
        end
      end
      if (q.tap == processor_jtag_debug_port_pkg::TAP_SH_DR) begin
        d.dr_sh = dr_shift(q.dr_sh, tdi, dr_len(q.ir_act));       // [R05] [R13]
      end
    end
    // output and update at test clock fall
    if (tck_fall) begin
      d.tdo_en = in_shift;                                        // [R10] [R25]
      if (q.tap == processor_jtag_debug_port_pkg::TAP_SH_IR) begin
        d.tdo = q.ir_sh[0];                                       // [R08] [R09]
      end else if (q.tap == processor_jtag_debug_port_pkg::TAP_SH_DR) begin
        d.tdo = chain_sel ? q.sy2[`SY_SCAN] : q.dr_sh[0];         // [R07] [R09]
      end
      if (q.tap == processor_jtag_debug_port_pkg::TAP_UPD_IR) begin
        d.ir_act = q.ir_sh;
      end
      if (q.tap == processor_jtag_debug_port_pkg::TAP_UPD_DR &&
          q.ir_act == `IR_DBGCTRL) begin
        d.dbg = q.dr_sh[`DBG_W-1:0];                              // [R14] [R15]
      end
    end
    if (q.tap == processor_jtag_debug_port_pkg::TAP_RESET) begin
      d.ir_act = `IR_IDCODE;                                      // [R24]
    end
    // debug sideband
    d.halted  = q.sy2[`SY_HALT] | q.dbg[`DBG_STOP_BIT];           // [R16] [R17]
    d.wb_full = core_wb_valid;                                    // [R20]
    d.wb_addr = core_wb_addr;
    d.wb_done = core_wb_valid & core_wb_done;                     // [R21]
    if (apb_wr && paddr == `OFS_CTRL) begin
      d.wse = pwdata[`CTRL_WSE_BIT];                              // [R22]
      if (pwdata[`CTRL_EVCLR_BIT]) begin
        d.evt_sticky = 1'b0;
      end
    end
    if (evt_rise) begin
      d.evt_sticky = 1'b1;                                        // [R18]
      d.evcnt      = `EVCNT_W'(q.evcnt + `EVCNT_W'(1));
    end
    // apb read data taken in setup cycle
    if (psel && !penable) begin
      d.slverr = 1'b0;
      unique case (paddr)
        `OFS_CTRL:   d.rdata = {31'h0, q.wse};
        `OFS_STATUS: d.rdata = {27'h0, (q.ir_act == `IR_EXTEST), q.dbg[`DBG_PGM_BIT],
                                q.sy2[`SY_BHA], q.evt_sticky, q.halted};   // [R19]
        `OFS_EVCNT:  d.rdata = {{(32-`EVCNT_W){1'b0}}, q.evcnt};
        default: begin
          d.rdata  = 32'h0000_0000;
          d.slverr = 1'b1;
        end
      endcase
    end
    // test reset clears everything behind the synchronisers
    if (jtag_rst) begin
      d          = ST_RST;                                        // [R06]
      d.sy1      = {bus_hold_ack_in, forced_debug_event_in, debug_halt_in, scan_chain_in,
                    test_reset_n, test_data_in, test_mode_select_in, test_clock_in};
      d.sy2      = q.sy1;
      d.tck_prev = q.sy2[`SY_TCK];
      d.evt_prev = q.sy2[`SY_EVT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= ST_RST;
    end else if (clk_en) begin
      q <= d;
    end
  end

  // outputs
  assign prdata                 = q.rdata;
  assign pready                 = 1'b1;
  assign pslverr                = q.slverr;
  assign test_data_out          = q.tdo;
  assign test_data_out_enable   = q.tdo_en;
  assign external_test_selected = (q.ir_act == `IR_EXTEST);               // [R11]
  assign capture_dr_flag        = (q.tap == processor_jtag_debug_port_pkg::TAP_CAP_DR); // [R12]
  assign shift_dr_flag          = (q.tap == processor_jtag_debug_port_pkg::TAP_SH_DR);  // [R13]
  assign update_dr_flag         = (q.tap == processor_jtag_debug_port_pkg::TAP_UPD_DR); // [R14]
  assign debug_program_bit_out  = q.dbg[`DBG_PGM_BIT];                    // [R15]
  assign writeback_full         = q.wb_full;
  assign writeback_instr_addr   = q.wb_addr;
  assign writeback_complete     = q.wb_done;
  assign wait_enable_out        = q.wse;
  assign halt_acknowledge       = q.halted;
  assign core_fetch_enable      = !q.halted && !q.wse;                    // [R16]

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn || !clk_en);

  sequence s_fall_in_shift_dr_chain;
    tck_fall && (q.tap == processor_jtag_debug_port_pkg::TAP_SH_DR) && chain_sel && !jtag_rst;
  endsequence

  sequence s_event_edge;
    evt_rise && !jtag_rst;
  endsequence

  a_tap_test_reset: assert property (jtag_rst |=> // [R06]
    q.tap == processor_jtag_debug_port_pkg::TAP_RESET && q.dbg == `DBG_RESET)
    else $error("tap not reset by test reset");
  a_tap_shift_exit: assert property (tck_rise && tms && !jtag_rst && // [R04]
    q.tap == processor_jtag_debug_port_pkg::TAP_SH_DR |=>
    q.tap == processor_jtag_debug_port_pkg::TAP_EX1_DR)
    else $error("shift dr did not exit on mode select high");
  a_tap_hold_still: assert property (!tck_rise && !jtag_rst |=> $stable(q.tap)) // [R01]
    else $error("tap moved without test clock rise");
  a_bypass_shift_in: assert property (tck_rise && !jtag_rst && q.ir_act == `IR_BYPASS && // [R13]
    q.tap == processor_jtag_debug_port_pkg::TAP_SH_DR |=> q.dr_sh[0] == $past(tdi))
    else $error("bypass bit did not take serial input");
  a_tdo_enable_shift: assert property (tck_fall && !jtag_rst |=> // [R10]
    test_data_out_enable == $past(in_shift))
    else $error("output enable wrong after falling edge");
  a_tdo_fall_only: assert property (!tck_fall && !jtag_rst |=> $stable(test_data_out)) // [R08]
    else $error("serial output changed off a falling edge");
  a_chain_passes: assert property (s_fall_in_shift_dr_chain |=> // [R07]
    test_data_out == $past(q.sy2[`SY_SCAN]))
    else $error("chain input not passed to serial output");
  a_extest_select: assert property (tck_fall && !jtag_rst && // [R11]
    q.tap == processor_jtag_debug_port_pkg::TAP_UPD_IR && q.ir_sh == `IR_EXTEST |=>
    external_test_selected ##1 external_test_selected || jtag_rst || tck_fall)
    else $error("extest flag not raised after update ir");
  a_idcode_capture: assert property (tck_rise && !jtag_rst && q.ir_act == `IR_IDCODE && // [R12]
    q.tap == processor_jtag_debug_port_pkg::TAP_CAP_DR |=> q.dr_sh == ID_CODE)
    else $error("identity value not captured");
  a_dbg_update_only: assert property (!jtag_rst && // [R14]
    q.tap != processor_jtag_debug_port_pkg::TAP_UPD_DR |=> $stable(q.dbg))
    else $error("debug control changed outside update dr");
  a_halt_stops_fetch: assert property (q.sy2[`SY_HALT] && !jtag_rst |=> // [R17]
    halt_acknowledge && !core_fetch_enable)
    else $error("halt not acknowledged");
  a_event_counted: assert property (s_event_edge |=> // [R18]
    q.evt_sticky && q.evcnt == `EVCNT_W'($past(q.evcnt) + `EVCNT_W'(1)))
    else $error("forced event not recorded");
  a_wb_complete_full: assert property (writeback_complete |-> writeback_full) // [R21]
    else $error("complete without full");
  a_wb_addr_follow: assert property (core_wb_valid && !jtag_rst |=> // [R20]
    writeback_full && writeback_instr_addr == $past(core_wb_addr))
    else $error("writeback address not reported");
  a_wait_enable_wr: assert property (apb_wr && paddr == `OFS_CTRL && !jtag_rst |=> // [R22]
    wait_enable_out == $past(pwdata[`CTRL_WSE_BIT]))
    else $error("wait enable output did not follow write");

endmodule

//--- testbench/jtag_debugger_model.sv
// behavioural external debugger on the test access pins
module jtag_debugger_model (
  // clock
  input  wire logic pclk,
  // test access pins
  input  wire logic tdo_line,
  output logic      tck,
  output logic      tms,
  output logic      tdi
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end
  // one test clock, tdo taken just before the rise
  task automatic bit_clk(input logic m, input logic d, output logic q);
    @(posedge pclk);
    tms <= m;
    tdi <= d;
    repeat (3) @(posedge pclk);
    q = tdo_line;
    tck <= 1'b1;
    repeat (4) @(posedge pclk);
    tck <= 1'b0;
  endtask
  // n clocks, tms and tdi lists lsb first
  task automatic walk(input int n, input logic [63:0] m, input logic [63:0] d,
                      output logic [63:0] q);
    logic b;
    q = '0;
    for (int i = 0; i < n; i++) begin
      bit_clk(m[i], d[i], b);
      q[i] = b;
    end
    @(posedge pclk);
    tms <= 1'b1;
    tdi <= 1'b1;
  endtask
  task automatic to_idle;
    logic [63:0] q;
    walk(6, 64'h1F, 64'h0, q);
  endtask
  // instruction scan from idle
  task automatic scan_ir(input logic [3:0] code, output logic [3:0] cap);
    logic [63:0] q;
    walk(10, {54'h0, 2'b01, 4'b1000, 4'b0011}, {56'h0, code, 4'h0}, q);
    cap = q[7:4];
  endtask
  // data scan of n bits from idle
  task automatic scan_dr(input int n, input logic [31:0] v, output logic [31:0] got);
    logic [63:0] m;
    logic [63:0] q;
    m = 64'h1 | (64'h1 << (n + 2)) | (64'h1 << (n + 3));
    walk(n + 5, m, {29'h0, v, 3'h0}, q);
    got = q[34:3];
  endtask
endmodule

//--- testbench/processor_jtag_debug_port_bench.sv
// self-checking bench of the jtag debug port
`include "processor_jtag_debug_port_regs.svh"
module processor_jtag_debug_port_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] ID = 32'h5A5A_0F0F;  // arbitrary value
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [`ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic pready, pslverr, tck, tms, tdi, test_reset_n = 1'b0, scan_chain_in = 1'b0;
  logic test_data_out, test_data_out_enable, external_test_selected;
  logic debug_program_bit_out, writeback_full, writeback_complete;
  logic bus_hold_ack_in = 1'b0, debug_halt_in = 1'b0, forced_debug_event_in = 1'b0;
  logic wait_enable_out, halt_acknowledge, core_fetch_enable;
  logic core_wb_valid = 1'b0, core_wb_done = 1'b0;
  logic [`WB_ADDR_W-1:0] writeback_instr_addr, core_wb_addr = '0;
  int err_total = 0, check_count = 0;
  logic clk_en = 1'b1, capture_dr_flag, shift_dr_flag, update_dr_flag;
  int cap_cyc = 0, sh_cyc = 0, upd_cyc = 0;
  wire tdo_line = test_data_out_enable ? test_data_out : 1'b1;
  always #10 pclk = ~pclk;
  // pclk cycles spent in each dr flag, sampled where settled
  always @(negedge pclk) begin
    if (capture_dr_flag === 1'b1) cap_cyc++;
    if (shift_dr_flag === 1'b1) sh_cyc++;
    if (update_dr_flag === 1'b1) upd_cyc++;
  end
  processor_jtag_debug_port #(.ID_CODE(ID)) u_processor_jtag_debug_port (
    .pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .test_clock_in(tck), .test_mode_select_in(tms),
    .test_data_in(tdi), .test_reset_n, .scan_chain_in, .test_data_out,
    .test_data_out_enable, .external_test_selected, .capture_dr_flag,
    .shift_dr_flag, .update_dr_flag, .debug_program_bit_out, .bus_hold_ack_in,
    .debug_halt_in, .forced_debug_event_in, .writeback_full, .writeback_instr_addr,
    .writeback_complete, .wait_enable_out, .halt_acknowledge, .core_wb_valid,
    .core_wb_addr, .core_wb_done, .core_fetch_enable);
  jtag_debugger_model u_jtag_debugger_model (.pclk, .tdo_line, .tck, .tms, .tdi);
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [`ADDR_W-1:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic t_scan;
    logic [3:0] c;
    logic [31:0] g;
    u_jtag_debugger_model.to_idle;
    chk("tdo enable idle", test_data_out_enable, 0);
    u_jtag_debugger_model.scan_dr(32, 32'h0, g);
    chk("idcode", g, ID);
    chk("capture cycles", cap_cyc, 8);
    chk("shift cycles", sh_cyc, 256);
    chk("update cycles", upd_cyc, 8);
    u_jtag_debugger_model.scan_ir(`IR_EXTEST, c);
    chk("ir capture", c, 4'h1);
    chk("extest", external_test_selected, 1);
    scan_chain_in <= 1'b1;
    u_jtag_debugger_model.scan_dr(4, 32'h0, g);
    chk("chain", g[3:0], 4'hF);
    u_jtag_debugger_model.scan_ir(`IR_BYPASS, c);
    chk("extest off", external_test_selected, 0);
    u_jtag_debugger_model.scan_dr(4, 32'hA, g);
    chk("bypass", g[3:0], 4'h4);
    $display("test scan done");
  endtask
  task automatic t_debug;
    logic [3:0] c;
    logic [31:0] g;
    logic e;
    u_jtag_debugger_model.scan_ir(`IR_DBGCTRL, c);
    u_jtag_debugger_model.scan_dr(8, 32'h3, g);
    chk("program bit", debug_program_bit_out, 1);
    chk("stop ack", halt_acknowledge, 1);
    chk("stop fetch", core_fetch_enable, 0);
    apb(0, `OFS_STATUS, 0, g, e);
    chk("status halted", g, 32'h9);
    test_reset_n <= 1'b0;
    repeat (4) @(posedge pclk);
    test_reset_n <= 1'b1;
    repeat (8) @(posedge pclk);
    chk("trst program bit", debug_program_bit_out, 0);
    chk("trst stop", halt_acknowledge, 0);
    $display("test debug done");
  endtask
  task automatic t_side;
    logic [31:0] r;
    logic e;
    debug_halt_in <= 1'b1;
    repeat (5) @(posedge pclk);
    chk("halt ack", halt_acknowledge, 1);
    chk("halt fetch", core_fetch_enable, 0);
    debug_halt_in <= 1'b0;
    bus_hold_ack_in <= 1'b1;
    repeat (2) begin
      forced_debug_event_in <= 1'b1;
      repeat (3) @(posedge pclk);
      forced_debug_event_in <= 1'b0;
      repeat (3) @(posedge pclk);
    end
    repeat (3) @(posedge pclk);
    chk("halt released", halt_acknowledge, 0);
    apb(0, `OFS_EVCNT, 0, r, e);
    chk("event count", r, 32'h2);
    apb(0, `OFS_STATUS, 0, r, e);
    chk("status", r, 32'h6);
    apb(1, `OFS_CTRL, 32'h3, r, e);
    repeat (2) @(posedge pclk);
    chk("wait enable", wait_enable_out, 1);
    apb(0, 12'h00C, 0, r, e);
    chk("unmapped", e, 1);
    core_wb_valid <= 1'b1;
    core_wb_addr <= 30'h2AAA_5555;
    core_wb_done <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("wb full", writeback_full, 1);
    chk("wb addr", writeback_instr_addr, 30'h2AAA_5555);
    chk("wb complete", writeback_complete, 1);
    core_wb_valid <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("wb complete off", writeback_complete, 0);
    clk_en <= 1'b0;
    core_wb_valid <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("frozen wb full", writeback_full, 0);
    clk_en <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("thawed wb full", writeback_full, 1);
    $display("test sideband done");
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    test_reset_n <= 1'b1;
    repeat (8) @(posedge pclk);
    t_scan;
    t_debug;
    t_side;
    report_and_stop;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    err_total++;
    report_and_stop;
  end
endmodule
